// *** fault_supervisor_pkg.sv ***
/*
  Constants, sense carrier and state types for the rail fault supervisor.
  Assumes one 20 MHz system clock and comparator flags already synchronous to it.
*/
`default_nettype none
package fault_supervisor_pkg;
  localparam int CLK_HZ = 20_000_000;
  localparam int STAGE_LAT_NS = 1000;
  localparam int STAGE_LAT_CYC = STAGE_LAT_NS * (CLK_HZ / 1_000_000) / 1000;
  localparam int SLOW_LAT_US = 950;
  localparam int SLOW_LAT_CYC = SLOW_LAT_US * (CLK_HZ / 1_000_000);
  localparam int INPUT_LAT_US = 525;
  localparam int INPUT_LAT_CYC = INPUT_LAT_US * (CLK_HZ / 1_000_000);
  localparam int HICCUP_US = 20000;
  localparam int HICCUP_CYC = HICCUP_US * (CLK_HZ / 1_000_000);
  localparam int FILT_SLACK = 2;
  localparam int NCOND = 12;
  localparam int NEV = 13;
  localparam int EV_OT_FAULT = 0;
  localparam int EV_OT_WARN = 1;
  localparam int EV_STAGE = 2;
  localparam int EV_NR = 3;
  localparam int EV_VOV_FAULT = 4;
  localparam int EV_VOV_WARN = 5;
  localparam int EV_VUV_WARN = 6;
  localparam int EV_VUV_FAULT = 7;
  localparam int EV_IOC_FAULT = 8;
  localparam int EV_IOC_WARN = 9;
  localparam int EV_PIN_WARN = 10;
  localparam int EV_COMM = 11;
  localparam int EV_STRAP = 12;
  localparam int NRESP = 5;
  localparam int RS_OT = 0;
  localparam int RS_STAGE = 1;
  localparam int RS_VOV = 2;
  localparam int RS_VUV = 3;
  localparam int RS_IOC = 4;
  localparam logic [1:0] RESP_IGNORE = 2'h0;
  localparam logic [1:0] RESP_LATCH = 2'h1;
  localparam logic [1:0] RESP_HICCUP = 2'h2;
  localparam logic [7:0] ADR_STATUS = 8'h00;
  localparam logic [7:0] ADR_MASK = 8'h04;
  localparam logic [7:0] ADR_CTRL = 8'h08;
  localparam logic [7:0] ADR_RESP = 8'h0c;
  localparam logic [7:0] ADR_PIN = 8'h10;
  localparam logic [7:0] ADR_STATE = 8'h14;
  localparam int CTRL_ENABLE = 0;
  localparam int CTRL_CLEAR = 1;
  localparam int PIN_W = 11;
  localparam logic [10:0] PIN_MIN = 11'h008;
  localparam logic [10:0] PIN_MAX = 11'h7fc;
  localparam logic [12:0] MASK_RESET = 13'h0000;
  localparam logic [9:0] RESP_RESET = 10'h155;
  typedef struct packed {
    logic temp_fault;
    logic temp_warn;
    logic stage_telemetry_high;
    logic stage_telemetry_low;
    logic stage_telemetry_clear;
    logic input_sense_ov_fault;
    logic input_sense_ov_warn;
    logic input_sense_uv_warn;
    logic input_sense_uv_fault;
    logic input_sense_above_on;
    logic input_oc_fault;
    logic input_oc_warn;
  } sense_t;
  typedef enum logic [2:0] {RAIL_OFF, RAIL_RUN, RAIL_LATCHED, RAIL_HICCUP, RAIL_DEAD} rail_state_t;
endpackage
`default_nettype wire

// *** fault_filter.sv ***
/*
  Persistence filter: hit rises once cond has held for COUNT enabled cycles.
  Assumes cond synchronous to clock; hit drops as soon as cond or enable drops.
*/
`timescale 1ns/1ps
`default_nettype none
module fault_filter #(
  parameter int COUNT = 18,
  parameter int W = 16
) (
  input wire logic clock,   // system clock
  input wire logic reset_n, // async reset
  input wire logic enable,  // detection window open
  input wire logic cond,    // raw condition
  output logic hit          // filtered condition
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic hit;
  } filt_t;
  filt_t q, d;

  always_comb
  begin
    d = q;
    if (!enable || !cond)
    begin
      d.cnt = '0;
      d.hit = 1'b0;
    end
    else if (q.cnt == W'(COUNT - 1))
      d.hit = 1'b1;
    else
      d.cnt = q.cnt + 1'b1;
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      q <= '0;
    else
      q <= d;
  end

  assign hit = q.hit;
endmodule
`default_nettype wire

// *** strap_checker.sv ***
/*
  Samples the address and boot strap verdicts once, when initialization completes.
  Assumes the strap decoder holds its verdicts steady while init_done rises.
*/
`timescale 1ns/1ps
`default_nettype none
module strap_checker (
  input wire logic clock,         // system clock
  input wire logic reset_n,       // async reset, the power cycle
  input wire logic init_done,     // initialization complete
  input wire logic addr_strap_ok, // address strap decoded valid
  input wire logic boot_strap_ok, // boot strap decoded valid
  output logic strap_bad          // latched invalid strap
);
  typedef struct packed {
    logic checked;
    logic bad;
  } strap_t;
  strap_t q, d;

  always_comb
  begin
    d = q;
    if (init_done && !q.checked)
    begin
      d.checked = 1'b1;
      d.bad = !(addr_strap_ok && boot_strap_ok);
    end
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      q <= '0;
    else
      q <= d;
  end

  assign strap_bad = q.bad;
endmodule
`default_nettype wire

// *** fault_supervisor.sv ***
/*
  Rail fault supervisor: filters stage and input conditions, keeps sticky status
  with alert mask, runs the rail state and its responses, Wishbone register slave.
  Assumes sense flags come from comparators synchronous to the 20 MHz clock.
*/
// Local design decisions: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
module fault_supervisor
  import fault_supervisor_pkg::*;
#(
  parameter int SLOW_CYCLES = SLOW_LAT_CYC,
  parameter int INPUT_CYCLES = INPUT_LAT_CYC,
  parameter int HICCUP_CYCLES = HICCUP_CYC
) (
  input wire logic clock,                 // 20 MHz system clock
  input wire logic reset_n,               // async reset, active low
  input wire logic init_done,             // initialization complete
  input wire sense_t sense,               // comparator flags
  input wire logic [PIN_W-1:0] input_power_w, // computed input power, watts
  input wire logic cml_error,             // communication error pulse
  input wire logic addr_strap_ok,         // address strap valid
  input wire logic boot_strap_ok,         // boot strap valid
  input wire logic wb_cyc_i,              // bus cycle
  input wire logic wb_stb_i,              // bus strobe
  input wire logic wb_we_i,               // bus write
  input wire logic [7:0] wb_adr_i,        // byte address
  input wire logic [31:0] wb_dat_i,       // write data
  input wire logic [3:0] wb_sel_i,        // byte enables
  output logic [31:0] wb_dat_o,           // read data
  output logic wb_ack_o,                  // bus acknowledge
  output logic regulator_ready_out,       // rail regulating
  output logic pwm_tristate_out,          // PWM outputs tristated
  output logic rail_fault_out_n,          // fault pin, low on fault
  output logic smb_alert_n,               // alert line, low on alert
  output logic irq                        // level interrupt
);
  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    rail_state_t rail;
    logic [NEV-1:0] status;
    logic [NEV-1:0] mask;
    logic enable;
    logic [2*NRESP-1:0] resp;
    logic ot_pin_en;
    logic [PIN_W-1:0] pin_limit;
    logic nr_raw;
    logic uv_arm;
    logic [19:0] hic_cnt;
    logic ack;
    logic [31:0] rdata;
    logic ready;
    logic pwm_tri;
    logic fault_n;
    logic alert_n;
    logic irq;
  } sup_t;
  sup_t q, d;

  localparam int FILT [NCOND] = '{
    SLOW_CYCLES - FILT_SLACK, SLOW_CYCLES - FILT_SLACK,
    STAGE_LAT_CYC - FILT_SLACK, STAGE_LAT_CYC - FILT_SLACK,
    SLOW_CYCLES - FILT_SLACK, SLOW_CYCLES - FILT_SLACK,
    SLOW_CYCLES - FILT_SLACK, SLOW_CYCLES - FILT_SLACK,
    INPUT_CYCLES - FILT_SLACK, INPUT_CYCLES - FILT_SLACK,
    INPUT_CYCLES - FILT_SLACK, 1};
  localparam int RESP_EV [NRESP] = '{
    EV_OT_FAULT, EV_STAGE, EV_VOV_FAULT, EV_VUV_FAULT, EV_IOC_FAULT};

  logic [NCOND-1:0] cond;
  logic [NCOND-1:0] win;
  logic [NCOND-1:0] hit;
  logic strap_bad;
  logic req;
  logic wr;
  logic [31:0] wmask;
  logic lat_cause;
  logic hic_cause;
  logic clr_all;
  logic run;
  logic uv_win;

  // ****************************************************************
  // detection
  // ****************************************************************
  assign run = q.rail == RAIL_RUN;
  assign uv_win = q.uv_arm && q.enable && init_done;
  assign cond = {cml_error, input_power_w > q.pin_limit, sense.input_oc_warn,
    sense.input_oc_fault, sense.input_sense_uv_fault, sense.input_sense_uv_warn,
    sense.input_sense_ov_warn, sense.input_sense_ov_fault, q.nr_raw,
    sense.stage_telemetry_high, sense.temp_warn, sense.temp_fault};
  assign win = {init_done, run, run, run, uv_win, uv_win,
    {6{init_done}}};

  for (genvar i = 0; i < NCOND; i++)
  begin : g_filt
    fault_filter #(.COUNT(FILT[i])) u_filt (
      .clock(clock),
      .reset_n(reset_n),
      .enable(win[i]),
      .cond(cond[i]),
      .hit(hit[i])
    );
  end

  strap_checker u_strap (
    .clock(clock),
    .reset_n(reset_n),
    .init_done(init_done),
    .addr_strap_ok(addr_strap_ok),
    .boot_strap_ok(boot_strap_ok),
    .strap_bad(strap_bad)
  );

  // ****************************************************************
  // bus and next state
  // ****************************************************************
  assign req = wb_cyc_i && wb_stb_i && !q.ack;
  assign wr = req && wb_we_i;
  assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  always_comb
  begin
    logic [31:0] merged;
    logic [NEV-1:0] keep;
    logic [1:0] r;
    logic clr_cmd;
    logic st_fault;
    d = q;
    merged = (wb_dat_i & wmask) | (32'(q.pin_limit) & ~wmask);
    keep = '1;
    r = RESP_IGNORE;
    clr_cmd = 1'b0;
    lat_cause = 1'b0;
    hic_cause = 1'b0;
    d.ack = req;
    d.rdata = '0;
    if (wr)
    begin
      case (wb_adr_i)
        ADR_STATUS: keep = ~(wb_dat_i[NEV-1:0] & wmask[NEV-1:0]);
        ADR_MASK: d.mask = (wb_dat_i[NEV-1:0] & wmask[NEV-1:0]) | (q.mask & ~wmask[NEV-1:0]);
        ADR_CTRL:
          if (wb_sel_i[0])
          begin
            d.enable = wb_dat_i[CTRL_ENABLE];
            clr_cmd = wb_dat_i[CTRL_CLEAR];
          end
        ADR_RESP:
        begin
          if (wb_sel_i[0])
            d.resp[7:0] = wb_dat_i[7:0];
          if (wb_sel_i[1])
            {d.ot_pin_en, d.resp[9:8]} = wb_dat_i[10:8];
        end
        ADR_PIN:
        begin
          d.pin_limit = merged[PIN_W-1:0];
          if (d.pin_limit < PIN_MIN)
            d.pin_limit = PIN_MIN;
          else if (d.pin_limit > PIN_MAX)
            d.pin_limit = PIN_MAX;
        end
        default: ;
      endcase
    end
    else if (req)
    begin
      case (wb_adr_i)
        ADR_STATUS: d.rdata = 32'(q.status);
        ADR_MASK: d.rdata = 32'(q.mask);
        ADR_CTRL: d.rdata = 32'(q.enable);
        ADR_RESP: d.rdata = 32'({q.ot_pin_en, q.resp});
        ADR_PIN: d.rdata = 32'(q.pin_limit);
        ADR_STATE: d.rdata = 32'({hit, q.rail, q.pwm_tri, q.ready});
        default: d.rdata = '0;
      endcase
    end
    // enable drop or clear command wipes every status bit but the strap flag and events whose hit is still set
    clr_all = clr_cmd || (q.enable && !d.enable);
    if (clr_all)
      keep = '0;
    keep[EV_STRAP] = 1'b1;
    d.status = (q.status & keep) | {strap_bad, hit};
    for (int k = 0; k < NRESP; k++)
    begin
      r = q.resp[2*k +: 2];
      if (hit[RESP_EV[k]] && r != RESP_IGNORE)
      begin
        if (r == RESP_HICCUP)
          hic_cause = 1'b1;
        else
          lat_cause = 1'b1;
      end
    end
    if (sense.stage_telemetry_low)
      d.nr_raw = 1'b1;
    else if (sense.stage_telemetry_clear)
      d.nr_raw = 1'b0;
    if (sense.input_sense_above_on)
      d.uv_arm = 1'b1;
    case (q.rail)
      RAIL_OFF:
        if (lat_cause)
          d.rail = RAIL_LATCHED;
        else if (d.enable && init_done && !hit[EV_NR] && !hic_cause
          && addr_strap_ok && boot_strap_ok)
          d.rail = RAIL_RUN;
      RAIL_RUN:
        if (lat_cause)
          d.rail = RAIL_LATCHED;
        else if (hic_cause)
        begin
          d.rail = RAIL_HICCUP;
          d.hic_cnt = '0;
        end
        else if (!d.enable || hit[EV_NR])
          d.rail = RAIL_OFF;
      RAIL_LATCHED:
        if (clr_all && !lat_cause && !hic_cause)
          d.rail = RAIL_OFF;
      RAIL_HICCUP:
        if (lat_cause)
          d.rail = RAIL_LATCHED;
        else if (clr_all && !hic_cause)
          d.rail = RAIL_OFF;
        else if (q.hic_cnt == 20'(HICCUP_CYCLES - 1))
        begin
          d.hic_cnt = '0;
          if (!hic_cause)
            d.rail = RAIL_OFF;
        end
        else
          d.hic_cnt = q.hic_cnt + 1'b1;
      RAIL_DEAD: ;
      default: d.rail = RAIL_OFF;
    endcase
    if (strap_bad)
      d.rail = RAIL_DEAD;
    d.ready = d.rail == RAIL_RUN;
    d.pwm_tri = d.rail != RAIL_RUN;
    st_fault = (d.status[EV_STAGE] && q.resp[2*RS_STAGE +: 2] != RESP_IGNORE)
      || (d.status[EV_IOC_FAULT] && q.resp[2*RS_IOC +: 2] != RESP_IGNORE)
      || (d.status[EV_OT_FAULT] && q.ot_pin_en && q.resp[2*RS_OT +: 2] != RESP_IGNORE);
    d.fault_n = !st_fault;
    d.alert_n = !(|(d.status & ~d.mask));
    d.irq = |(d.status & ~d.mask);
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      q <= '{rail: RAIL_OFF, mask: MASK_RESET, resp: RESP_RESET, pin_limit: PIN_MAX,
        pwm_tri: 1'b1, fault_n: 1'b1, alert_n: 1'b1, default: '0};
    else
      q <= d;
  end

  assign wb_dat_o = q.rdata;
  assign wb_ack_o = q.ack;
  assign regulator_ready_out = q.ready;
  assign pwm_tristate_out = q.pwm_tri;
  assign rail_fault_out_n = q.fault_n;
  assign smb_alert_n = q.alert_n;
  assign irq = q.irq;

  // ****************************************************************
  // checks
  // ****************************************************************
  logic [7:0] nr_hold_q;
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      nr_hold_q <= '0;
    else if (!(q.nr_raw && init_done))
      nr_hold_q <= '0;
    else if (nr_hold_q != 8'hff)
      nr_hold_q <= nr_hold_q + 1'b1;
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  a_ready_drop: assert property (run && (lat_cause || hic_cause) |=> !regulator_ready_out)
    else $error("ready kept through shutdown");
  a_alert_event: assert property ((|(hit & ~q.mask[NCOND-1:0])) && !wr |=> !smb_alert_n && irq)
    else $error("unmasked event without alert");
  a_clear_retrig: assert property (clr_all |=> (q.status[NCOND-1:0] & $past(hit)) == $past(hit))
    else $error("clear lost a present condition");
  a_clear_done: assert property (clr_all && !(|hit) && !strap_bad |=> q.status == '0)
    else $error("clear left status set");
  a_stage_latency: assert property (nr_hold_q == 8'(STAGE_LAT_CYC - 1) |-> q.status[EV_NR])
    else $error("not-ready seen too late");
  a_not_ready_off: assert property (hit[EV_NR] |=> pwm_tristate_out && !regulator_ready_out)
    else $error("rail running while stage not ready");
  a_fault_pin: assert property (hit[EV_STAGE] && q.resp[2*RS_STAGE +: 2] != RESP_IGNORE
    |=> !rail_fault_out_n)
    else $error("stage fault without fault pin");
  a_power_warn: assert property (run && hit[EV_PIN_WARN] && !lat_cause && !hic_cause
    && !hit[EV_NR] && !strap_bad && !wr |=> run && q.status[EV_PIN_WARN])
    else $error("power warning disturbed conversion");
  a_strap_dead: assert property (strap_bad |=> q.rail == RAIL_DEAD && pwm_tristate_out)
    else $error("bad strap did not latch off");
  a_latch_tri: assert property (run && lat_cause |=> q.rail == RAIL_LATCHED ##1 pwm_tristate_out)
    else $error("latch-off response missing");
  a_hiccup_retry: assert property (q.rail == RAIL_HICCUP && !hic_cause && !lat_cause && !strap_bad
    && q.hic_cnt == 20'(HICCUP_CYCLES - 1) |=> q.rail == RAIL_OFF)
    else $error("hiccup did not retry");

  c_hiccup: cover property (q.rail == RAIL_HICCUP ##1 q.rail == RAIL_OFF);
  c_latch_clear: cover property (q.rail == RAIL_LATCHED ##1 q.rail == RAIL_OFF);
  c_alert: cover property ($fell(smb_alert_n));
endmodule
`default_nettype wire

// *** stage_model.sv ***
/*
  Stage and input-side model: turns analog pin levels into comparator flags.
  Assumes the bench changes levels right after a rising clock edge.
*/
`timescale 1ns/1ps
`default_nettype none
module stage_model
  import fault_supervisor_pkg::*;
#(
  parameter int HIGH_MV = 2500,
  parameter int LOW_MV = 230,
  parameter int HYST_MV = 50
) (
  input wire logic clock,            // system clock
  input wire logic reset_n,          // async reset
  input wire logic [11:0] stage_mv,  // telemetry pin level, mV
  input wire logic [1:0] temp_level, // 0 cool, 1 warm, 2 hot
  output var sense_t sense           // comparator flags
);
  // ********************
  // comparators
  // ********************
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sense <= '0;
    end
    else
    begin
      sense <= '0;
      sense.stage_telemetry_high <= stage_mv > HIGH_MV;
      sense.stage_telemetry_low <= stage_mv < LOW_MV;
      sense.stage_telemetry_clear <= stage_mv >= LOW_MV + HYST_MV;
      sense.temp_fault <= temp_level == 2'h2;
      sense.temp_warn <= temp_level != 2'h0;
      sense.input_sense_above_on <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// *** test_fault_supervisor.sv ***
/*
  Self-checking bench for fault_supervisor: Wishbone tasks, random power limits.
  Assumes the stage model drives sense and short simulation counts.
*/
`timescale 1ns/1ps
`default_nettype none
module test_fault_supervisor;
  import fault_supervisor_pkg::*;
  localparam int SLOW = 40;
  localparam int INP = 30;
  logic clock, reset_n, init_done, cml_error, addr_strap_ok, boot_strap_ok;
  logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, regulator_ready_out, pwm_tristate_out;
  logic rail_fault_out_n, smb_alert_n, irq;
  logic [7:0] wb_adr_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd, lim, seed;
  logic [3:0] wb_sel_i;
  logic [PIN_W-1:0] input_power_w;
  logic [11:0] stage_mv;
  logic [1:0] temp_level;
  sense_t sense;
  int mismatches, n_tests;
  stage_model model (.clock, .reset_n, .stage_mv, .temp_level, .sense);
  fault_supervisor #(.SLOW_CYCLES(SLOW), .INPUT_CYCLES(INP), .HICCUP_CYCLES(50)) dut (
    .clock, .reset_n, .init_done, .sense, .input_power_w, .cml_error, .addr_strap_ok,
    .boot_strap_ok, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_sel_i,
    .wb_dat_o, .wb_ack_o, .regulator_ready_out, .pwm_tristate_out, .rail_fault_out_n,
    .smb_alert_n, .irq);
  // ********************
  // helpers
  // ********************
  task automatic test_done;
    $display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0)
    begin
      $display("== PASSED ==");
    end
    else
    begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_pin(input logic got, input logic exp);
    chk_reg({31'h0, got}, {31'h0, exp});
  endtask
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [31:0] clamp(input logic [31:0] v);
    return (v < 8) ? 32'h8 : (v > 2044) ? 32'h7fc : v;
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      mismatches++;
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge clock);
  endtask
  task automatic en_cycle;
    wb(1'b1, ADR_CTRL, 32'h0);
    wb(1'b1, ADR_CTRL, 32'h1);
  endtask
  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  initial
  begin
    #(8000 * 50);
    mismatches++;
    test_done();
  end
  // ********************
  // scenarios
  // ********************
  initial
  begin
    {reset_n, init_done, cml_error, wb_cyc_i, wb_stb_i, wb_we_i} = '0;
    {addr_strap_ok, boot_strap_ok} = 2'h3;
    wb_adr_i = 8'h0;
    wb_dat_i = 32'h0;
    wb_sel_i = 4'h0;
    input_power_w = '0;
    stage_mv = 12'd500;
    temp_level = 2'h0;
    seed = 32'd1216;
    mismatches = 0;
    n_tests = 0;
    cyc(2);
    reset_n <= 1'b1;
    cyc(1);
    chk_pin(regulator_ready_out, 1'b0);
    wb(1'b0, ADR_MASK, 32'h0);
    chk_reg(rd, {19'h0, MASK_RESET});
    wb(1'b0, ADR_RESP, 32'h0);
    chk_reg(rd, {22'h0, RESP_RESET});
    wb(1'b0, 8'h40, 32'h0);
    chk_reg(rd, 32'h0);
    init_done <= 1'b1;
    wb(1'b1, ADR_CTRL, 32'h1);
    cyc(3);
    chk_pin(regulator_ready_out, 1'b1);
    stage_mv <= 12'd100;
    cyc(23);
    chk_pin(regulator_ready_out, 1'b0);
    chk_pin(pwm_tristate_out, 1'b1);
    chk_pin(smb_alert_n, 1'b0);
    stage_mv <= 12'd250;
    cyc(25);
    wb(1'b1, ADR_CTRL, 32'h3);
    cyc(3);
    chk_pin(pwm_tristate_out, 1'b1);
    wb(1'b0, ADR_STATUS, 32'h0);
    chk_reg(rd & 32'h8, 32'h8);
    stage_mv <= 12'd300;
    cyc(25);
    wb(1'b1, ADR_CTRL, 32'h3);
    cyc(3);
    chk_pin(regulator_ready_out, 1'b1);
    wb(1'b0, ADR_STATUS, 32'h0);
    chk_reg(rd, 32'h0);
    for (int s = 0; s < 2; s++)
    begin
      for (int c = 0; c < 3; c++)
      begin
        wb(1'b1, ADR_RESP, (s == 0) ? (32'h151 | (c << 2)) : (32'h554 | c));
        if (s == 0)
        begin
          stage_mv <= 12'd3000;
        end
        else
        begin
          temp_level <= 2'h2;
        end
        cyc((s == 0) ? 23 : SLOW + 6);
        chk_pin(rail_fault_out_n, c == 0);
        chk_pin(pwm_tristate_out, c != 0);
        chk_pin(regulator_ready_out, c == 0);
        stage_mv <= 12'd500;
        temp_level <= 2'h0;
        cyc(2);
        en_cycle();
        cyc(60);
        chk_pin(regulator_ready_out, 1'b1);
        chk_pin(smb_alert_n, 1'b1);
      end
    end
    wb(1'b1, ADR_MASK, 32'h800);
    cml_error <= 1'b1;
    cyc(1);
    cml_error <= 1'b0;
    cyc(4);
    wb(1'b0, ADR_STATUS, 32'h0);
    chk_reg(rd, 32'h800);
    chk_pin(smb_alert_n, 1'b1);
    wb(1'b1, ADR_MASK, 32'h0);
    cyc(2);
    chk_pin(irq, 1'b1);
    wb(1'b1, ADR_STATUS, 32'h800);
    cyc(2);
    chk_pin(smb_alert_n, 1'b1);
    for (int i = 0; i < 8; i++)
    begin
      lim = (i == 0) ? 32'h7ff : (i == 1) ? 32'h3 : {21'h0, rnd() & 32'h7ff};
      wb(1'b1, ADR_PIN, lim);
      lim = clamp(lim);
      wb(1'b0, ADR_PIN, 32'h0);
      chk_reg(rd, lim);
      input_power_w <= (i < 2) ? lim[PIN_W-1:0] + 11'h1 : (i == 2) ? lim[PIN_W-1:0] : rnd();
      cyc(2);
      wb(1'b1, ADR_STATUS, 32'h400);
      cyc(INP + 4);
      wb(1'b0, ADR_STATUS, 32'h0);
      chk_reg(rd & 32'h400, ({21'h0, input_power_w} > lim) ? 32'h400 : 32'h0);
      chk_pin(regulator_ready_out, 1'b1);
    end
    reset_n <= 1'b0;
    addr_strap_ok <= 1'b0;
    init_done <= 1'b0;
    cyc(2);
    reset_n <= 1'b1;
    cyc(1);
    init_done <= 1'b1;
    wb(1'b1, ADR_CTRL, 32'h1);
    cyc(4);
    chk_pin(regulator_ready_out, 1'b0);
    chk_pin(pwm_tristate_out, 1'b1);
    wb(1'b1, ADR_CTRL, 32'h3);
    cyc(2);
    wb(1'b0, ADR_STATUS, 32'h0);
    chk_reg(rd & 32'h1000, 32'h1000);
    test_done();
  end
endmodule
`default_nettype wire
